//--- core/sao_cfg.svh
// Constants for the strap address offset loader
`ifndef SAO_CFG_SVH
`define SAO_CFG_SVH
`define SAO_STRAP_W      4
`define SAO_ADDR_W       8
`define SAO_BASE_DEFAULT 8'h04
`define SAO_OFFSET_SHIFT 1
`define SAO_SETTLE_CYC   4
`define SAO_CNT_W        3
`endif

//--- core/sao_offset_calc.sv
// Combinational offset and address calculation from captured straps
`timescale 1ns/1ns
`default_nettype none
`include "sao_cfg.svh"
module sao_offset_calc
  import sao_pkg::*;
(
  // Inputs
  input  wire sao_strap_t strapRaw,
  input  wire sao_addr_t  baseAddr,
  // Results
  output var   sao_addr_t offset,
  output var   sao_addr_t finalAddr
);
  function automatic sao_addr_t strapToOffset(input sao_strap_t s);
    sao_addr_t v;
    v = {{(`SAO_ADDR_W - `SAO_STRAP_W){1'h0}}, ~s};
    return sao_addr_t'(v << `SAO_OFFSET_SHIFT);
  endfunction : strapToOffset

  always_comb begin
    offset    = strapToOffset(strapRaw);
    finalAddr = sao_addr_t'(baseAddr + offset);
  end
endmodule : sao_offset_calc
`default_nettype wire

//--- core/sao_pkg.sv
// Types for the strap address offset loader
`default_nettype none
`include "sao_cfg.svh"
package sao_pkg;
  typedef logic [`SAO_STRAP_W-1:0] sao_strap_t;
  typedef logic [`SAO_ADDR_W-1:0]  sao_addr_t;
  typedef struct packed {
    logic      valid;
    sao_addr_t addr;
    sao_addr_t offset;
  } sao_result_t;
  typedef enum logic [1:0] {SaoIdle, SaoSettle, SaoDone} sao_state_t;
endpackage : sao_pkg
`default_nettype wire

//--- core/sao_strap_loader.sv
// Boot-time strap capture that forms the module network address
`timescale 1ns/1ns
`default_nettype none
`include "sao_cfg.svh"
module sao_strap_loader
  import sao_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Boot control
  input  wire logic        softReset,
  // Straps and base
  input  wire sao_strap_t  strapPin,
  input  wire sao_addr_t   baseAddr,
  // Result
  output var  sao_result_t result
);

  // ----------------------------------------
  // Local state
  // ----------------------------------------
  // Sequencer
  sao_state_t              state_q;
  logic [`SAO_CNT_W-1:0]   cnt_q;

  // Captured straps and result fields
  sao_strap_t              strap_q;
  logic                    valid_q;
  sao_addr_t               offset_q;
  sao_addr_t               addr_q;

  // Arithmetic results
  sao_addr_t               offsetW;
  sao_addr_t               addrW;

  // Phase decode
  logic                    inIdle;
  logic                    inSettle;
  logic                    inDone;
  logic                    settleLast;
  logic                    captureEn;
  logic                    loadEn;

  // ----------------------------------------
  // Counter helpers
  // ----------------------------------------
  // Last cycle of the strap settle window
  function automatic logic lastSettleCycle(
    input logic [`SAO_CNT_W-1:0] c
  );
    return c == `SAO_CNT_W'(`SAO_SETTLE_CYC - 1);
  endfunction : lastSettleCycle

  // Step the settle counter without widening
  function automatic logic [`SAO_CNT_W-1:0] incCount(
    input logic [`SAO_CNT_W-1:0] c
  );
    return `SAO_CNT_W'(c + 1'h1);
  endfunction : incCount

  // ----------------------------------------
  // Phase decode
  // ----------------------------------------
  // A pending restart masks every phase
  always_comb begin
    inIdle   = 1'h0;
    inSettle = 1'h0;
    inDone   = 1'h0;
    if (!softReset) begin
      unique case (state_q)
        SaoIdle: begin
          inIdle = 1'h1;
        end
        SaoSettle: begin
          inSettle = 1'h1;
        end
        SaoDone: begin
          inDone = 1'h1;
        end
        // Unused code decodes as no phase
        default: begin
          inIdle = 1'h0;
        end
      endcase
    end
  end

  // Window end and load enables for the registers below
  assign settleLast = inSettle && lastSettleCycle(cnt_q);
  assign captureEn  = inSettle;
  assign loadEn     = inDone;

  // ----------------------------------------
  // Boot sequencing
  // ----------------------------------------
  // Any restart re-runs the strap window from the start
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= SaoIdle;
    end else if (softReset) begin
      state_q <= SaoIdle;
    end else begin
      unique case (state_q)
        // Idle lasts one cycle, then the straps settle
        SaoIdle: begin
          state_q <= SaoSettle;
        end
        SaoSettle: begin
          if (settleLast) begin
            state_q <= SaoDone;
          end
        end
        SaoDone: begin
          state_q <= SaoDone;
        end
        // Unused code falls back to a clean restart
        default: begin
          state_q <= SaoIdle;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Settle window counter
  // ----------------------------------------
  // Holds at the last count once settled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (softReset || inIdle) begin
      cnt_q <= '0;
    end else if (inSettle && !settleLast) begin
      cnt_q <= incCount(cnt_q);
    end
  end

  // ----------------------------------------
  // Strap capture, only while booting
  // ----------------------------------------
  // Every settle cycle samples, the last sample wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strap_q <= '1;
    end else if (softReset) begin
      strap_q <= '1;
    end else if (captureEn) begin
      strap_q <= strapPin;
    end
  end

  // ----------------------------------------
  // Offset and address arithmetic
  // ----------------------------------------
  // Straps read inverted, so grounded pins add
  sao_offset_calc sao_offset_calc_inst (
    .strapRaw  (strap_q),
    .baseAddr  (baseAddr),
    .offset    (offsetW),
    .finalAddr (addrW)
  );

  // ----------------------------------------
  // Result valid flag
  // ----------------------------------------
  // Cleared on restart so a stale address never reads as valid
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      valid_q <= 1'h0;
    end else if (softReset) begin
      valid_q <= 1'h0;
    end else if (loadEn) begin
      valid_q <= 1'h1;
    end
  end

  // ----------------------------------------
  // Offset register
  // ----------------------------------------
  // Reloaded from the held straps while done
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      offset_q <= '0;
    end else if (softReset) begin
      offset_q <= '0;
    end else if (loadEn) begin
      offset_q <= offsetW;
    end
  end

  // ----------------------------------------
  // Address register
  // ----------------------------------------
  // Follows the base input for as long as the block is done
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_q <= '0;
    end else if (softReset) begin
      addr_q <= '0;
    end else if (loadEn) begin
      addr_q <= addrW;
    end
  end

  // ----------------------------------------
  // Result packing
  // ----------------------------------------
  // Every field comes straight from a flop
  always_comb begin
    result.valid  = valid_q;
    result.addr   = addr_q;
    result.offset = offset_q;
  end

endmodule : sao_strap_loader
`default_nettype wire

//--- tb/sao_loader_sva.sv
// Checker for the strap address loader
`timescale 1ns/1ns
`default_nettype none
module sao_loader_sva import sao_pkg::*; (
  input wire logic        clk, nrst, softReset,
  input wire sao_strap_t  strapPin,
  input wire sao_addr_t   baseAddr,
  input wire sao_result_t result);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_offset_shape: assert property (result.valid |-> result.offset < 8'h1F && !result.offset[0])
    else $error("bad offset");
  a_addr_sum: assert property (result.valid && $past(result.valid) |->
    result.addr == $past(baseAddr) + result.offset) else $error("bad addr");
  a_offset_hold: assert property (result.valid && $past(result.valid) |->
    $stable(result.offset)) else $error("offset moved");
  a_boot_time: assert property ($fell(softReset) |-> ##[1:8] result.valid) else $error("no boot");
  a_soft_clear: assert property (softReset |=> !result.valid) else $error("valid in reset");
  cover property ($rose(result.valid));
  cover property (result.valid && result.offset == 8'h1E);
  cover property (softReset && result.valid);
endmodule : sao_loader_sva
bind sao_strap_loader sao_loader_sva sao_loader_sva_inst (.clk, .nrst, .softReset, .strapPin,
  .baseAddr, .result);
`default_nettype wire

//--- tb/sao_strap_board.sv
// Carrier board straps: grounded reads low, floating pulled high
`timescale 1ns/1ns
`default_nettype none
module sao_strap_board import sao_pkg::*; (
  input  wire logic [3:0] grounded,
  output wire sao_strap_t strapPin);
  assign strapPin = ~grounded;
endmodule : sao_strap_board
`default_nettype wire

//--- tb/test_sao_strap_loader.sv
// Self-checking bench for the strap address loader
`timescale 1ns/1ns
`default_nettype none
module test_sao_strap_loader import sao_pkg::*; ;
  logic        clk = 0, nrst = 0, softReset = 0;
  logic [3:0]  gnd = 0, g0;
  sao_addr_t   baseAddr = 8'h04;
  sao_strap_t  strapPin;
  sao_result_t result;
  int          mismatches = 0, compares = 0, seed = 9, i, k, r;
  always #4 clk = ~clk;
  sao_strap_board sao_strap_board_inst (.grounded(gnd), .strapPin);
  sao_strap_loader sao_strap_loader_inst (.clk, .nrst, .softReset, .strapPin, .baseAddr, .result);
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  function automatic sao_addr_t expOff(input logic [3:0] g);
    return {3'h0, g, 1'b0};
  endfunction : expOff
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1;
    for (i = 0; i < 24; i++) begin
      r = $random(seed);
      gnd = (i < 16) ? i[3:0] : r[3:0];
      baseAddr = (i < 16) ? 8'h04 : r[11:4];
      if (i[0]) nrst = 0;
      else softReset = 1;
      @(negedge clk);
      nrst = 1;
      softReset = 0;
      for (k = 0; k < 20 && result.valid !== 1'b1; k++) @(negedge clk);
      if (k == 20) begin
        mismatches++;
        break;
      end
      g0 = gnd;
      check({result.offset, result.addr}, {expOff(g0), baseAddr + expOff(g0)});
      gnd = ~g0;
      baseAddr = baseAddr + 8'h01;
      repeat (2) @(negedge clk);
      check({result.offset, result.addr}, {expOff(g0), baseAddr + expOff(g0)});
    end
    report_and_stop();
  end
endmodule : test_sao_strap_loader
`default_nettype wire
